// ### rtl/sgc_map.vh
// sgc_map.vh: offsets, field positions, reset values and timing counts of the switch global control bank
// assumes a 125 MHz pclk and one 8-bit register per APB word
`ifndef SGC_MAP_VH
`define SGC_MAP_VH

// printed register indices; byte address is four times the index
`define SGC_IDX_GC0 8'h02
`define SGC_IDX_GC1 8'h03
`define SGC_IDX_GC2 8'h04
`define SGC_REG_W 8

// reset values
`define SGC_RST_GC0 8'h44
`define SGC_RST_GC1 8'h30
`define SGC_RST_GC2 8'hE0
`define SGC_GC2_LOW_MASK 8'hE0

// global control zero fields
`define SGC_GC0_NEW_BACKOFF 7
`define SGC_GC0_PASS_FC 3
`define SGC_GC0_LINK_AGE 0
// global control one fields
`define SGC_GC1_PASS_ALL 7
`define SGC_GC1_TX_FC 5
`define SGC_GC1_RX_FC 4
`define SGC_GC1_LEN_CHK 3
`define SGC_GC1_AGE_EN 2
`define SGC_GC1_FAST_AGE 1
`define SGC_GC1_AGGR_BACKOFF 0
// global control two fields
`define SGC_GC2_VLAN_DISCARD 7
`define SGC_GC2_STORM_BCAST_ONLY 6
`define SGC_GC2_BP_CARRIER 5

// frame length check limit
`define SGC_LEN_LIMIT 16'd1500

// timing: clock period in ns, fast age period in us, normal age period in s
`define SGC_CLK_NS 8
`define SGC_FAST_AGE_US 800
`define SGC_NORMAL_AGE_S 200
// cycles per microsecond, rounded down (shortest time)
`define SGC_CYC_PER_US (1000 / `SGC_CLK_NS)
// fast age period in cycles, an upper bound so rounded down
`define SGC_FAST_AGE_CYC (`SGC_FAST_AGE_US * 1000 / `SGC_CLK_NS)
// normal age period in microseconds
`define SGC_NORMAL_AGE_USEC (`SGC_NORMAL_AGE_S * 1000000)

`endif

// ### rtl/sgc_apb_slave.v
// sgc_apb_slave.v: apb slave decoding three 8-bit control registers
// assumes an apb master on pclk; answers every access with zero wait states
`default_nettype none

module sgc_apb_slave (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output reg [31:0] prdata,
    output reg pslverr,
    // register contents
    output reg [7:0] gc0_ff,
    output reg [7:0] gc1_ff,
    output reg [7:0] gc2_ff
);
`include "sgc_map.vh"

    // word index from a byte address; unaligned addresses never match
    function [9:0] word_idx;
        input [11:0] a;
        begin
            word_idx = (a[1:0] == 2'b00) ? a[11:2] : 10'h3FF;
        end
    endfunction

    wire [9:0] idx = word_idx(paddr);
    wire hit0 = (idx == {2'b00, `SGC_IDX_GC0});
    wire hit1 = (idx == {2'b00, `SGC_IDX_GC1});
    wire hit2 = (idx == {2'b00, `SGC_IDX_GC2});
    wire hit = hit0 | hit1 | hit2;
    wire acc = psel & penable;
    // byte lane 0 carries the register; other lanes ignored
    wire wr = acc & pwrite & pstrb[0];

    assign pready = 1'b1;

    // register writes take effect at once, no reset needed
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gc0_ff <= `SGC_RST_GC0;
            gc1_ff <= `SGC_RST_GC1;
            gc2_ff <= `SGC_RST_GC2;
        end else if (wr) begin
            if (hit0) begin
                gc0_ff <= pwdata[7:0];
            end else if (hit1) begin
                gc1_ff <= pwdata[7:0];
            end else if (hit2) begin
                // low bits of this register belong to fields outside this bank
                gc2_ff <= (pwdata[7:0] & `SGC_GC2_LOW_MASK) | (`SGC_RST_GC2 & ~`SGC_GC2_LOW_MASK);
            end
        end
    end

    // read data and error, registered in the setup phase so they stand during access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (psel & ~penable) begin
            pslverr <= ~hit;
            if (hit0) begin
                prdata <= {24'h000000, gc0_ff};
            end else if (hit1) begin
                prdata <= {24'h000000, gc1_ff};
            end else if (hit2) begin
                prdata <= {24'h000000, gc2_ff};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end
endmodule
`default_nettype wire

// ### rtl/sgc_age_timer.v
// sgc_age_timer.v: address table aging pacer, normal, fast and link-loss sweeps
// assumes link_up is synchronous to pclk, one bit per port
`default_nettype none
`include "sgc_map.vh"

module sgc_age_timer #(
    parameter FAST_CYC = `SGC_FAST_AGE_CYC,
    parameter NORMAL_US = `SGC_NORMAL_AGE_USEC
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // settings
    input wire age_en,
    input wire fast_en,
    input wire link_age_en,
    input wire [2:0] link_up,
    // results
    output reg age_tick_ff,
    output reg flush_all_ff,
    output reg fast_active_ff
);
    // divider reload, one less than the cycles in a microsecond
    localparam integer US_RELOAD_I = `SGC_CYC_PER_US - 1;
    localparam [6:0] US_RELOAD = US_RELOAD_I[6:0];

    reg [2:0] link_d_ff;
    reg [6:0] us_ff;
    reg [31:0] age_cnt_ff;
    reg [31:0] sweep_ff;
    wire us_tick = (us_ff == 7'd0);
    wire link_drop = |(link_d_ff & ~link_up);
    wire trig = link_age_en & link_drop;

    // microsecond enable pulse from pclk
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            us_ff <= 7'd0;
        end else begin
            us_ff <= us_tick ? US_RELOAD : us_ff - 7'd1;
        end
    end

    // link loss starts a fast sweep that flushes every entry
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_d_ff <= 3'b000;
            sweep_ff <= 32'h00000000;
            flush_all_ff <= 1'b0;
            fast_active_ff <= 1'b0;
        end else begin
            link_d_ff <= link_up;
            flush_all_ff <= trig;
            if (trig) begin
                sweep_ff <= FAST_CYC - 1;
                fast_active_ff <= 1'b1;
            end else if (sweep_ff != 32'h00000000) begin
                sweep_ff <= sweep_ff - 32'd1;
            end else begin
                fast_active_ff <= 1'b0;
            end
        end
    end

    // age tick, only with aging enabled or in a sweep: 800 us in fast mode or sweep, otherwise about 200 s
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age_cnt_ff <= 32'h00000000;
            age_tick_ff <= 1'b0;
        end else begin
            age_tick_ff <= 1'b0;
            if (!age_en && !fast_active_ff) begin
                age_cnt_ff <= 32'h00000000;
            end else if (fast_en || fast_active_ff) begin
                if (age_cnt_ff >= FAST_CYC - 1) begin
                    age_cnt_ff <= 32'h00000000;
                    age_tick_ff <= 1'b1;
                end else begin
                    age_cnt_ff <= age_cnt_ff + 32'd1;
                end
            end else if (us_tick) begin
                if (age_cnt_ff >= NORMAL_US - 1) begin
                    age_cnt_ff <= 32'h00000000;
                    age_tick_ff <= 1'b1;
                end else begin
                    age_cnt_ff <= age_cnt_ff + 32'd1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### rtl/sgc_top.v
// sgc_top.v: global control register bank of a three-port switch and the decisions it steers
// assumes apb on pclk, and engine status inputs synchronous to pclk
//
// Register access over APB is this design's own decision.
`default_nettype none
`include "sgc_map.vh"

module sgc_top #(
    parameter FAST_CYC = `SGC_FAST_AGE_CYC,
    parameter NORMAL_US = `SGC_NORMAL_AGE_USEC
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output wire pready,
    output wire [31:0] prdata,
    output wire pslverr,
    // link status per port
    input wire [2:0] link_up,
    // frame under classification
    input wire frm_valid,
    input wire frm_bad,
    input wire frm_is_pause,
    input wire frm_is_fc,
    input wire [15:0] frm_len_type,
    input wire [15:0] frm_actual_len,
    input wire [47:0] frm_da,
    input wire frm_known_ucast,
    input wire frm_cross_vlan,
    input wire sniffer_mode,
    input wire mirror_req,
    input wire pause_req,
    // frame verdict
    output reg fwd_ok_ff,
    output reg drop_ff,
    output reg storm_count_ff,
    output reg mirror_ok_ff,
    output reg pause_tx_ff,
    output reg pause_honor_ff,
    // mac and lookup settings
    output reg new_backoff_ff,
    output reg aggr_backoff_ff,
    output reg bp_carrier_ff,
    output reg age_tick_ff,
    output reg flush_all_ff,
    output reg fast_age_ff
);

    wire [7:0] gc0_ff;
    wire [7:0] gc1_ff;
    wire [7:0] gc2_ff;
    wire age_tick;
    wire flush_all;
    wire fast_active;

    // register file; one byte per word, live effect
    sgc_apb_slave u_bus (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .pready(pready),
        .prdata(prdata),
        .pslverr(pslverr),
        .gc0_ff(gc0_ff),
        .gc1_ff(gc1_ff),
        .gc2_ff(gc2_ff)
    );

    // aging pacer
    sgc_age_timer #(
        .FAST_CYC(FAST_CYC),
        .NORMAL_US(NORMAL_US)
    ) u_age (
        .pclk(pclk),
        .presetn(presetn),
        .age_en(gc1_ff[`SGC_GC1_AGE_EN]),
        .fast_en(gc1_ff[`SGC_GC1_FAST_AGE]),
        .link_age_en(gc0_ff[`SGC_GC0_LINK_AGE]),
        .link_up(link_up),
        .age_tick_ff(age_tick),
        .flush_all_ff(flush_all),
        .fast_active_ff(fast_active)
    );

    wire pass_fc = gc0_ff[`SGC_GC0_PASS_FC];
    wire pass_all = gc1_ff[`SGC_GC1_PASS_ALL];
    wire len_chk = gc1_ff[`SGC_GC1_LEN_CHK];
    wire vlan_boundary_discard = gc2_ff[`SGC_GC2_VLAN_DISCARD];
    wire bcast_only = gc2_ff[`SGC_GC2_STORM_BCAST_ONLY];

    // verdict terms
    wire len_bad = len_chk & (frm_len_type < `SGC_LEN_LIMIT) & (frm_len_type != frm_actual_len);
    wire vlan_block = frm_cross_vlan & (vlan_boundary_discard | ~frm_known_ucast);
    wire is_bcast = &frm_da;
    wire is_mcast = frm_da[40];
    reg nxt_fwd;
    reg nxt_drop;

    // forward decision; every filter is lifted under pass-all with sniffer
    always @* begin
        nxt_fwd = 1'b1;
        // bad frames dropped by default
        if (frm_bad) begin
            nxt_fwd = 1'b0;
        end
        if (frm_is_fc && !pass_fc) begin
            nxt_fwd = 1'b0;
        end
        if (len_bad) begin
            nxt_fwd = 1'b0;
        end
        if (vlan_block) begin
            nxt_fwd = 1'b0;
        end
        // pass all frames; debug only, so it needs sniffer as well
        if (pass_all && sniffer_mode) begin
            nxt_fwd = 1'b1;
        end
        nxt_drop = frm_valid & ~nxt_fwd;
        nxt_fwd = frm_valid & nxt_fwd;
    end

    // registered verdict, one cycle after frm_valid
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fwd_ok_ff <= 1'b0;
            drop_ff <= 1'b0;
            storm_count_ff <= 1'b0;
            mirror_ok_ff <= 1'b0;
        end else begin
            fwd_ok_ff <= nxt_fwd;
            drop_ff <= nxt_drop;
            storm_count_ff <= frm_valid & (is_bcast | (~bcast_only & is_mcast));
            mirror_ok_ff <= frm_valid & mirror_req & vlan_boundary_discard;
        end
    end

    // pause handling, gated live by the enables
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pause_tx_ff <= 1'b0;
            pause_honor_ff <= 1'b0;
        end else begin
            pause_tx_ff <= pause_req & gc1_ff[`SGC_GC1_TX_FC];
            pause_honor_ff <= frm_valid & frm_is_pause & gc1_ff[`SGC_GC1_RX_FC];
        end
    end

    // mac and lookup settings, one register stage so outputs leave from flops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            new_backoff_ff <= 1'b0;
            aggr_backoff_ff <= 1'b0;
            bp_carrier_ff <= 1'b1;
            age_tick_ff <= 1'b0;
            flush_all_ff <= 1'b0;
            fast_age_ff <= 1'b0;
        end else begin
            new_backoff_ff <= gc0_ff[`SGC_GC0_NEW_BACKOFF];
            aggr_backoff_ff <= gc1_ff[`SGC_GC1_AGGR_BACKOFF];
            bp_carrier_ff <= gc2_ff[`SGC_GC2_BP_CARRIER];
            age_tick_ff <= age_tick;
            flush_all_ff <= flush_all;
            fast_age_ff <= fast_active | gc1_ff[`SGC_GC1_FAST_AGE];
        end
    end
endmodule
`default_nettype wire

// ### tb/sgc_top_assertions.sv
// sgc_top_assertions.sv: port-level checks of the switch global control bank
// assumes zero-wait apb and frame verdicts one edge after frm_valid
`default_nettype none
module sgc_chk (
    // clock, reset and apb
    input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic [3:0] pstrb,
    // link and frame inputs
    input wire logic [2:0] link_up,
    input wire logic frm_valid, frm_is_pause, frm_cross_vlan, sniffer_mode, pause_req,
    input wire logic [15:0] frm_len_type, frm_actual_len,
    input wire logic [47:0] frm_da,
    // verdicts and settings
    input wire logic fwd_ok_ff, drop_ff, storm_count_ff, mirror_ok_ff, pause_tx_ff, pause_honor_ff,
    input wire logic new_backoff_ff, aggr_backoff_ff, bp_carrier_ff, flush_all_ff
);
    logic [7:0] sh0_ff, sh1_ff, sh2_ff;
    logic [1:0] quiet_ff;
    logic wr, hit, da_all, da40;
    assign wr = psel & penable & pwrite & pstrb[0];
    assign hit = paddr == 12'h008 || paddr == 12'h00C || paddr == 12'h010;
    assign da_all = &frm_da;
    assign da40 = frm_da[40];
    // shadow bank; quiet saturates once settings had time to settle after a write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh0_ff <= 8'h44;
            sh1_ff <= 8'h30;
            sh2_ff <= 8'hE0;
            quiet_ff <= 2'h3;
        end else begin
            if (wr && paddr == 12'h008) sh0_ff <= pwdata[7:0];
            if (wr && paddr == 12'h00C) sh1_ff <= pwdata[7:0];
            if (wr && paddr == 12'h010) sh2_ff <= pwdata[7:0] & 8'hE0;
            quiet_ff <= wr ? 2'h0 : (quiet_ff == 2'h3 ? 2'h3 : quiet_ff + 2'h1);
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_read_back: assert property (psel && penable && !pwrite && hit |-> !pslverr && prdata ==
        {24'h0, paddr == 12'h008 ? sh0_ff : (paddr == 12'h00C ? sh1_ff : sh2_ff)}) else $error("read value wrong");
    a_bad_addr: assert property (psel && penable && !hit |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    a_settings_map: assert property (quiet_ff == 2'h3 |-> new_backoff_ff == sh0_ff[7] &&
        aggr_backoff_ff == sh1_ff[0] && bp_carrier_ff == sh2_ff[5]) else $error("setting output wrong");
    a_pause_gen: assert property (quiet_ff == 2'h3 && $past(presetn) |->
        pause_tx_ff == ($past(pause_req) & sh1_ff[5])) else $error("pause generation wrong");
    a_pause_react: assert property ($past(presetn & frm_valid & frm_is_pause) && quiet_ff == 2'h3 |->
        pause_honor_ff == sh1_ff[4]) else $error("pause reaction wrong");
    a_pulse_only: assert property (!$past(frm_valid) |->
        !(fwd_ok_ff | drop_ff | storm_count_ff | mirror_ok_ff | pause_honor_ff)) else $error("stray verdict");
    a_len_drop: assert property ($past(presetn & frm_valid & !sniffer_mode & (frm_len_type < 16'd1500) &
        (frm_len_type != frm_actual_len)) && sh1_ff[3] && quiet_ff == 2'h3 |-> drop_ff && !fwd_ok_ff)
        else $error("length mismatch not dropped");
    a_vlan_block: assert property ($past(presetn & frm_valid & frm_cross_vlan & !sniffer_mode) &&
        sh2_ff[7] && quiet_ff == 2'h3 |-> drop_ff && !fwd_ok_ff) else $error("vlan crossing passed");
    a_mirror_gate: assert property (quiet_ff == 2'h3 && !sh2_ff[7] |-> !mirror_ok_ff)
        else $error("mirror allowed");
    a_storm_scope: assert property ($past(presetn & frm_valid) && quiet_ff == 2'h3 |->
        storm_count_ff == ($past(da_all) | (!sh2_ff[6] & $past(da40)))) else $error("storm scope wrong");
    a_link_flush: assert property ($past(presetn) && |($past(link_up) & ~link_up) && sh0_ff[0] &&
        quiet_ff == 2'h3 |-> ##[1:4] flush_all_ff) else $error("no flush after link loss");
endmodule
bind sgc_top sgc_chk u_chk (.*);
`default_nettype wire

// ### tb/tb_sgc.sv
// tb_sgc.sv: self-checking bench for the switch global control bank
// assumes the bank header on the include path; age counts shortened by parameter
`default_nettype none
`include "sgc_map.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0] pstrb = 4'hF;
    logic [2:0] link_up = 3'h7;
    logic frm_valid = 0, frm_bad = 0, frm_is_pause = 0, frm_is_fc = 0, frm_known_ucast = 0, frm_cross_vlan = 0;
    logic sniffer_mode = 0, mirror_req = 0, pause_req = 0;
    logic [15:0] frm_len_type = '0, frm_actual_len = '0;
    logic [47:0] frm_da = '0;
    logic fwd_ok_ff, drop_ff, storm_count_ff, mirror_ok_ff, pause_tx_ff, pause_honor_ff;
    logic new_backoff_ff, aggr_backoff_ff, bp_carrier_ff, age_tick_ff, flush_all_ff, fast_age_ff;
    logic [7:0] g0, g1, g2;
    int n_errors = 0, samples_checked = 0, n;
    sgc_top #(.FAST_CYC(20), .NORMAL_US(5)) DUT (.*);
    initial forever #4 pclk = ~pclk;
    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chkw(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chkw({31'h0, got}, {31'h0, exp});
    endtask
    // one apb transfer; data and error are taken at the edge that samples pready high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never completes
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    function automatic logic [7:0] gval(input int i);
        return i == 0 ? g0 : (i == 1 ? g1 : g2);
    endfunction
    // read all three registers back, then the steered settings
    task automatic regchk();
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, 12'(8 + 4 * i), 32'h0);
            chkw(rd, {24'h0, gval(i)});
            chkb(er, 1'b0);
        end
        chkb(new_backoff_ff, g0[7]);
        chkb(aggr_backoff_ff, g1[0]);
        chkb(bp_carrier_ff, g2[5]);
    endtask
    // count pulses of flush (sel) or age tick over c cycles
    task automatic ticks(input int c, input logic sel, output int m);
        m = 0;
        repeat (c) begin
            @(negedge pclk);
            m += sel ? int'(flush_all_ff === 1'b1) : int'(age_tick_ff === 1'b1);
        end
        @(posedge pclk);
    endtask
    task automatic frame();
        logic b, fc, ps, cv, sn, ku, dr, mr, pr;
        logic [15:0] lt, al;
        logic [47:0] da;
        b = $urandom % 4 == 0;
        fc = $urandom % 4 == 0;
        ps = $urandom % 2;
        sn = $urandom % 4 == 0;
        cv = !sn && $urandom % 2;
        ku = $urandom % 2;
        lt = $urandom % 2 ? 16'd1498 + 16'($urandom % 4) : 16'($urandom % 1500);
        al = $urandom % 2 ? lt : lt + 16'h1;
        da = {16'($urandom), $urandom};
        if ($urandom % 3 == 0) da = '1;
        else da[40] = $urandom % 2;
        mr = $urandom % 2;
        pr = $urandom % 2;
        dr = !(g1[7] && sn) && (b || (fc && !g0[3]) || (g1[3] && lt < 16'd1500 && lt != al) || (cv && (g2[7] || !ku)));
        frm_valid <= 1'b1;
        {frm_bad, frm_is_fc, frm_is_pause, sniffer_mode, frm_cross_vlan, frm_known_ucast} <= {b, fc, ps, sn, cv, ku};
        {frm_len_type, frm_actual_len, frm_da} <= {lt, al, da};
        {mirror_req, pause_req} <= {mr, pr};
        @(posedge pclk);
        frm_valid <= 1'b0;
        @(negedge pclk);
        chkb(drop_ff, dr);
        chkb(fwd_ok_ff, !dr);
        chkb(pause_honor_ff, ps & g1[4]);
        chkb(storm_count_ff, (&da) | (!g2[6] & da[40]));
        chkb(mirror_ok_ff, mr & g2[7]);
        chkb(pause_tx_ff, pr & g1[5]);
        @(posedge pclk);
    endtask
    initial begin
        #320000;
        n_errors++;
        close_out();
    end
    initial begin
        void'($urandom(79));
        g0 = 8'h44;
        g1 = 8'h30;
        g2 = 8'hE0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        regchk();
        // unmapped places refuse reads and unaligned places refuse both reads and writes with an error
        foreach (g0[i]) begin
            apb(i[0], 12'(i * 5 + 4 * (i / 4)), 32'hFFFF_FFFF);
            chkb(er, 1'b1);
        end
        for (int it = 0; it < 24; it++) begin
            g0 = (8'($urandom) & 8'h89) | 8'h44;
            g1 = 8'($urandom) & 8'hBF;
            g2 = 8'($urandom);
            apb(1'b1, 12'h008, {24'($urandom), g0});
            apb(1'b1, 12'h00C, {24'($urandom), g1});
            apb(1'b1, 12'h010, {24'($urandom), g2});
            g2 = g2 & 8'hE0;
            regchk();
            repeat (4) frame();
        end
        apb(1'b1, 12'h00C, 32'h30);
        // let a tick launched at the write edge drain first
        repeat (2) @(posedge pclk);
        ticks(300, 1'b0, n);
        chkb(n == 0, 1'b1);
        apb(1'b1, 12'h00C, 32'h36);
        ticks(200, 1'b0, n);
        chkb(n >= 9 && n <= 11, 1'b1);
        chkb(fast_age_ff, 1'b1);
        apb(1'b1, 12'h00C, 32'h34);
        ticks(2000, 1'b0, n);
        chkb(n >= 2 && n <= 4, 1'b1);
        chkb(fast_age_ff, 1'b0);
        apb(1'b1, 12'h008, 32'h45);
        repeat (4) @(posedge pclk);
        link_up <= 3'h5;
        ticks(12, 1'b1, n);
        chkb(n == 1, 1'b1);
        chkb(fast_age_ff, 1'b1);
        ticks(30, 1'b0, n);
        chkb(n >= 1, 1'b1);
        chkb(fast_age_ff, 1'b0);
        link_up <= 3'h7;
        apb(1'b1, 12'h008, 32'h44);
        repeat (4) @(posedge pclk);
        link_up <= 3'h3;
        ticks(12, 1'b1, n);
        chkb(n == 0, 1'b1);
        close_out();
    end
endmodule
`default_nettype wire
